// ---- nvs_sequencer.sv ----
// Nonvolatile memory read/write sequencer with APB register access
//
// Behaviour
// - A write never starts while the write enable bit is clear, even with write start set.
// - Write start launches a write, is cleared by hardware at the end, and software cannot clear it.
// - A completed write sets the write complete flag in peripheral_flags_two.
// - A data EEPROM write erases the low-address location and then programs the low data byte.
// - During a data EEPROM write the processor keeps running.
// - A program memory write halts the processor, erases and programs high:low, sets the flag, then resumes.
// - An external or watchdog reset during a write sets the write error flag; a completed write clears it.
// - External and watchdog resets leave data, address and memory select registers unchanged.
// - Bits 6 to 4 of the access control register read as zero.
module nvs_sequencer
    import nvs_pkg::*;
#(
    parameter int TIMER_WIDTH = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        warm_reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             cpu_halt,
    output logic             mem_select_prog,
    output logic [13:0]      mem_addr,
    output logic [13:0]      mem_wdata,
    input  wire logic [13:0] mem_rdata,
    output logic             mem_read,
    output logic             mem_erase,
    output logic             mem_program
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    nvs_state_e state_ff;
    nvs_state_e nxt_state;
    logic [7:0] address_low_ff;
    logic [7:0] nxt_address_low;
    logic [5:0] address_high_ff;
    logic [5:0] nxt_address_high;
    logic [7:0] data_low_ff;
    logic [7:0] nxt_data_low;
    logic [5:0] data_high_ff;
    logic [5:0] nxt_data_high;
    logic       mem_select_ff;
    logic       nxt_mem_select;
    logic       write_enable_ff;
    logic       nxt_write_enable;
    logic       write_start_ff;
    logic       nxt_write_start;
    logic       read_start_ff;
    logic       nxt_read_start;
    logic       write_error_ff;
    logic       nxt_write_error;
    logic       write_complete_ff;
    logic       nxt_write_complete;

    logic                   timer_load;
    logic [TIMER_WIDTH-1:0] timer_value;
    logic                   timer_expired;
    logic                   apb_write;
    logic                   apb_read;
    logic                   busy;
    logic                   known_addr;
    logic [31:0]            nxt_prdata;
    logic [31:0]            prdata_ff;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign apb_write = psel && penable && pwrite && pstrb[0];
    assign apb_read  = psel && !penable && !pwrite;
    assign busy      = (state_ff != NVS_IDLE);
    assign pready    = 1'b1;

    // Unmapped address flag
    always_comb begin
        known_addr = 1'b1;
        if (paddr == NVS_ACCESS_CONTROL_ADDR) begin
            known_addr = 1'b1;
        end else if (paddr == NVS_ADDRESS_LOW_ADDR) begin
            known_addr = 1'b1;
        end else if (paddr == NVS_ADDRESS_HIGH_ADDR) begin
            known_addr = 1'b1;
        end else if (paddr == NVS_DATA_LOW_ADDR) begin
            known_addr = 1'b1;
        end else if (paddr == NVS_DATA_HIGH_ADDR) begin
            known_addr = 1'b1;
        end else if (paddr == NVS_FLAGS_TWO_ADDR) begin
            known_addr = 1'b1;
        end else begin
            known_addr = 1'b0;
        end
    end
    assign pslverr = psel && penable && !known_addr;

    // Read data, captured in the setup cycle
    always_comb begin
        nxt_prdata = prdata_ff;
        if (apb_read) begin
            nxt_prdata = 32'h0000_0000;
            if (paddr == NVS_ACCESS_CONTROL_ADDR) begin
                nxt_prdata[NVS_MEM_SELECT_BIT]   = mem_select_ff;
                nxt_prdata[NVS_WRITE_ERROR_BIT]  = write_error_ff;
                nxt_prdata[NVS_WRITE_ENABLE_BIT] = write_enable_ff;
                nxt_prdata[NVS_WRITE_START_BIT]  = write_start_ff;
                nxt_prdata[NVS_READ_START_BIT]   = read_start_ff; // Bits 6:4 stay zero
            end else if (paddr == NVS_ADDRESS_LOW_ADDR) begin
                nxt_prdata[7:0] = address_low_ff;
            end else if (paddr == NVS_ADDRESS_HIGH_ADDR) begin
                nxt_prdata[5:0] = address_high_ff;
            end else if (paddr == NVS_DATA_LOW_ADDR) begin
                nxt_prdata[7:0] = data_low_ff;
            end else if (paddr == NVS_DATA_HIGH_ADDR) begin
                nxt_prdata[5:0] = data_high_ff;
            end else if (paddr == NVS_FLAGS_TWO_ADDR) begin
                nxt_prdata[NVS_WRITE_COMPLETE_BIT] = write_complete_ff;
            end
        end
    end
    assign prdata = prdata_ff;

    // ------------------------------------------------------------
    // Registers and sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state          = state_ff;
        nxt_address_low    = address_low_ff;
        nxt_address_high   = address_high_ff;
        nxt_data_low       = data_low_ff;
        nxt_data_high      = data_high_ff;
        nxt_mem_select     = mem_select_ff;
        nxt_write_enable   = write_enable_ff;
        nxt_write_start    = write_start_ff;
        nxt_read_start     = read_start_ff;
        nxt_write_error    = write_error_ff;
        nxt_write_complete = write_complete_ff;
        timer_load         = 1'b0;
        timer_value        = '0;

        // Software writes
        if (apb_write) begin
            if (paddr == NVS_ACCESS_CONTROL_ADDR) begin
                if (!busy) begin
                    nxt_mem_select = pwdata[NVS_MEM_SELECT_BIT]; // Held during access
                end
                nxt_write_enable = pwdata[NVS_WRITE_ENABLE_BIT];
                nxt_write_error  = pwdata[NVS_WRITE_ERROR_BIT];
                if (pwdata[NVS_WRITE_START_BIT] && write_enable_ff) begin
                    nxt_write_start = 1'b1; // Set only, gated by enable
                end
                if (pwdata[NVS_READ_START_BIT]) begin
                    nxt_read_start = 1'b1; // Set only
                end
            end else if (paddr == NVS_ADDRESS_LOW_ADDR && !busy) begin
                nxt_address_low = pwdata[7:0];
            end else if (paddr == NVS_ADDRESS_HIGH_ADDR && !busy) begin
                nxt_address_high = pwdata[5:0];
            end else if (paddr == NVS_DATA_LOW_ADDR && !busy) begin
                nxt_data_low = pwdata[7:0];
            end else if (paddr == NVS_DATA_HIGH_ADDR && !busy) begin
                nxt_data_high = pwdata[5:0];
            end else if (paddr == NVS_FLAGS_TWO_ADDR) begin
                nxt_write_complete = pwdata[NVS_WRITE_COMPLETE_BIT];
            end
        end

        // Sequencer
        case (state_ff)
            NVS_IDLE: begin
                if (write_start_ff && write_enable_ff) begin
                    nxt_state   = NVS_ERASE; // Erase first
                    timer_load  = 1'b1;
                    timer_value = TIMER_WIDTH'(NVS_ERASE_CYCLES);
                end else if (write_start_ff) begin
                    nxt_write_start = 1'b0; // Refused while disabled
                end else if (read_start_ff) begin
                    nxt_state = NVS_READ;
                end
            end
            NVS_READ: begin
                nxt_data_low   = mem_rdata[7:0]; // Fetch into data registers
                nxt_read_start = 1'b0;
                nxt_state      = NVS_IDLE;
                if (mem_select_ff) begin
                    nxt_data_high = mem_rdata[13:8];
                end
            end
            NVS_ERASE: begin
                if (timer_expired) begin
                    nxt_state   = NVS_PROGRAM;
                    timer_load  = 1'b1;
                    timer_value = TIMER_WIDTH'(NVS_PROG_CYCLES);
                end
            end
            NVS_PROGRAM: begin
                if (timer_expired) begin
                    nxt_state = NVS_DONE;
                end
            end
            NVS_DONE: begin
                nxt_write_start    = 1'b0; // Hardware clear at end
                nxt_write_complete = 1'b1; // Set wins over software clear
                nxt_write_error    = 1'b0; // Completed write
                nxt_state          = NVS_IDLE;
            end
            default: begin
                nxt_state = NVS_IDLE;
            end
        endcase

        // Warm reset aborts the write; data, address, select kept
        if (warm_reset) begin
            if (state_ff == NVS_ERASE || state_ff == NVS_PROGRAM) begin
                nxt_write_error = 1'b1; // Interrupted write
            end
            nxt_state        = NVS_IDLE;
            nxt_write_enable = 1'b0;
            nxt_write_start  = 1'b0;
            nxt_read_start   = 1'b0;
        end
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff          <= NVS_IDLE;
            address_low_ff    <= NVS_BYTE_RESET;
            address_high_ff   <= NVS_HIGH_RESET;
            data_low_ff       <= NVS_BYTE_RESET;
            data_high_ff      <= NVS_HIGH_RESET;
            mem_select_ff     <= 1'b0;
            write_enable_ff   <= 1'b0;
            write_start_ff    <= 1'b0;
            read_start_ff     <= 1'b0;
            write_error_ff    <= 1'b0;
            write_complete_ff <= 1'b0;
            prdata_ff         <= 32'h0000_0000;
        end else begin
            state_ff          <= nxt_state;
            address_low_ff    <= nxt_address_low;
            address_high_ff   <= nxt_address_high;
            data_low_ff       <= nxt_data_low;
            data_high_ff      <= nxt_data_high;
            mem_select_ff     <= nxt_mem_select;
            write_enable_ff   <= nxt_write_enable;
            write_start_ff    <= nxt_write_start;
            read_start_ff     <= nxt_read_start;
            write_error_ff    <= nxt_write_error;
            write_complete_ff <= nxt_write_complete;
            prdata_ff         <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------
    nvs_timer #(
        .WIDTH      (TIMER_WIDTH)
    ) u_timer (
        .clk        (clk),
        .reset      (reset),
        .load       (timer_load),
        .load_value (timer_value),
        .expired    (timer_expired)
    );

    // ------------------------------------------------------------
    // Array interface and processor stall
    // ------------------------------------------------------------
    assign cpu_halt = mem_select_ff && (state_ff == NVS_ERASE || state_ff == NVS_PROGRAM
                      || state_ff == NVS_DONE); // Only program writes stall
    assign mem_select_prog = mem_select_ff; // Target choice
    assign mem_addr    = mem_select_ff ? {address_high_ff, address_low_ff} : {6'h00, address_low_ff};
    assign mem_wdata   = mem_select_ff ? {data_high_ff, data_low_ff} : {6'h00, data_low_ff};
    assign mem_read    = (state_ff == NVS_READ);
    assign mem_erase   = (state_ff == NVS_ERASE);
    assign mem_program = (state_ff == NVS_PROGRAM);

endmodule

// ---- nvs_pkg.sv ----
// Package: register map, field positions, timing for the nonvolatile write sequencer
package nvs_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (APB, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [11:0] NVS_ACCESS_CONTROL_ADDR = 12'h18c;
    localparam logic [11:0] NVS_ADDRESS_LOW_ADDR    = 12'h190;
    localparam logic [11:0] NVS_ADDRESS_HIGH_ADDR   = 12'h194;
    localparam logic [11:0] NVS_DATA_LOW_ADDR       = 12'h198;
    localparam logic [11:0] NVS_DATA_HIGH_ADDR      = 12'h19c;
    localparam logic [11:0] NVS_FLAGS_TWO_ADDR      = 12'h1a0;

    // ------------------------------------------------------------
    // Field positions in the access control register
    // ------------------------------------------------------------
    localparam int NVS_READ_START_BIT   = 0;
    localparam int NVS_WRITE_START_BIT  = 1;
    localparam int NVS_WRITE_ENABLE_BIT = 2;
    localparam int NVS_WRITE_ERROR_BIT  = 3;
    localparam int NVS_MEM_SELECT_BIT   = 7;

    // Write-complete flag position in peripheral_flags_two
    localparam int NVS_WRITE_COMPLETE_BIT = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NVS_BYTE_RESET = 8'h00;
    localparam logic [5:0] NVS_HIGH_RESET = 6'h00;

    // ------------------------------------------------------------
    // Timing of the memory array operations
    // ------------------------------------------------------------
    localparam int NVS_CLK_MHZ       = 50;
    localparam int NVS_ERASE_TIME_US = 2;
    localparam int NVS_PROG_TIME_US  = 2;
    localparam int NVS_ERASE_CYCLES  = NVS_ERASE_TIME_US * NVS_CLK_MHZ;
    localparam int NVS_PROG_CYCLES   = NVS_PROG_TIME_US * NVS_CLK_MHZ;

    // Sequencer states
    typedef enum logic [2:0] {
        NVS_IDLE,
        NVS_READ,
        NVS_ERASE,
        NVS_PROGRAM,
        NVS_DONE
    } nvs_state_e;

endpackage

// ---- nvs_timer.sv ----
// Down-counter that times one erase or program phase
module nvs_timer
    import nvs_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  expired
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;

    // Next count: load, decrement, or hold at zero
    always_comb begin
        nxt_count = count_ff;
        if (load) begin
            nxt_count = load_value;
        end else if (count_ff != '0) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // Register the count
    always_ff @(posedge clk) begin
        if (reset) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Expiry once the counter reaches one
    assign expired = (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

// ---- nvs_mem_model.sv ----
// Behavioural model of the program flash and data EEPROM arrays
module nvs_mem_model
    import nvs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sel_prog,
    input  wire logic [13:0] addr,
    input  wire logic [13:0] wdata,
    input  wire logic        rd,
    input  wire logic        erase,
    input  wire logic        prog,
    output logic [13:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] flash [16384];
    logic [7:0]  eeprom [256];
    logic [13:0] last;

    initial last = 14'h0000;

    // Answer on read, inverted last value while rd is low
    always_comb rdata = rd ? (sel_prog ? flash[addr] : {6'h00, eeprom[addr[7:0]]}) : ~last;

    // Erase to ones, then program, in the array picked by select
    always @(posedge clk) begin
        if (rd) last <= rdata;
        if (erase && sel_prog) flash[addr] <= 14'h3fff;
        if (erase && !sel_prog) eeprom[addr[7:0]] <= 8'hff;
        if (prog && sel_prog) flash[addr] <= wdata;
        if (prog && !sel_prog) eeprom[addr[7:0]] <= wdata[7:0];
    end
endmodule

// ---- nvs_sequencer_checker.sv ----
// Concurrent checks on the sequencer ports
module nvs_sequencer_checker
    import nvs_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        warm_reset,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        cpu_halt,
    input wire logic        mem_select_prog,
    input wire logic [13:0] mem_addr,
    input wire logic        mem_read,
    input wire logic        mem_erase,
    input wire logic        mem_program
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] erase_cnt_ff;
    logic [15:0] prog_cnt_ff;
    logic        start_wr;

    // Phase length counters and start request decode
    always_ff @(posedge clk) begin
        erase_cnt_ff <= (reset || !mem_erase) ? 16'h0000 : erase_cnt_ff + 16'h0001;
        prog_cnt_ff  <= (reset || !mem_program) ? 16'h0000 : prog_cnt_ff + 16'h0001;
    end
    assign start_wr = psel && penable && pwrite && pstrb[0] && paddr == NVS_ACCESS_CONTROL_ADDR
                      && pwdata[NVS_WRITE_START_BIT];

    sequence s_erase_end;
        $fell(mem_erase) && !$past(warm_reset) && !$past(reset);
    endsequence
    sequence s_prog_end;
        $fell(mem_program) && !$past(warm_reset) && !$past(reset);
    endsequence

    property p_start_cause;
        $rose(mem_erase) |-> $past(start_wr) || $past(start_wr, 2);
    endproperty
    property p_erase_len;
        s_erase_end |-> erase_cnt_ff == NVS_ERASE_CYCLES;
    endproperty
    property p_erase_then_prog;
        s_erase_end |-> mem_program;
    endproperty
    property p_prog_len;
        s_prog_end |-> prog_cnt_ff == NVS_PROG_CYCLES;
    endproperty
    property p_resume;
        s_prog_end and mem_select_prog |-> cpu_halt ##1 !cpu_halt;
    endproperty
    property p_data_runs;
        (mem_erase || mem_program) && !mem_select_prog |-> !cpu_halt;
    endproperty
    property p_prog_halts;
        (mem_erase || mem_program) && mem_select_prog |-> cpu_halt;
    endproperty
    property p_abort;
        warm_reset && (mem_erase || mem_program) |=> !mem_erase && !mem_program;
    endproperty
    property p_keep;
        warm_reset && !psel |=> mem_addr == $past(mem_addr) && mem_select_prog == $past(mem_select_prog);
    endproperty
    property p_sel_fixed;
        mem_program |-> $stable(mem_select_prog) && $stable(mem_addr);
    endproperty
    property p_read_short;
        $rose(mem_read) |=> !mem_read;
    endproperty

    a_start_cause: assert property (p_start_cause) else $error("erase without start");
    a_erase_len: assert property (p_erase_len) else $error("erase length");
    a_erase_then_prog: assert property (p_erase_then_prog) else $error("no program");
    a_prog_len: assert property (p_prog_len) else $error("program length");
    a_resume: assert property (p_resume) else $error("halt not released");
    a_data_runs: assert property (p_data_runs) else $error("halt in data write");
    a_prog_halts: assert property (p_prog_halts) else $error("no halt");
    a_abort: assert property (p_abort) else $error("warm reset no abort");
    a_keep: assert property (p_keep) else $error("warm reset lost state");
    a_sel_fixed: assert property (p_sel_fixed) else $error("select moved");
    a_read_short: assert property (p_read_short) else $error("read stuck");
endmodule

bind nvs_sequencer nvs_sequencer_checker u_chk (.clk, .reset, .warm_reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .cpu_halt, .mem_select_prog, .mem_addr, .mem_read, .mem_erase, .mem_program);

// ---- nvs_sequencer_bench.sv ----
// Self-checking bench for the nonvolatile write sequencer
module nvs_sequencer_bench
    import nvs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, warm_reset, psel, penable, pwrite, pready, pslverr, cpu_halt, msel, mrd, mer, mpr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic [3:0]  pstrb;
    logic [13:0] maddr, mwd, mrdata, d;
    logic [7:0]  lo;
    logic        sel;
    int          num_errors, compares, i, n;

    nvs_sequencer uut (.clk(clk), .reset(reset), .warm_reset(warm_reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halt(cpu_halt), .mem_select_prog(msel), .mem_addr(maddr), .mem_wdata(mwd),
        .mem_rdata(mrdata), .mem_read(mrd), .mem_erase(mer), .mem_program(mpr));
    nvs_mem_model mem (.clk(clk), .sel_prog(msel), .addr(maddr), .wdata(mwd), .rd(mrd), .erase(mer),
        .prog(mpr), .rdata(mrdata));

    always #10 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [13:0] exp_word(logic s, logic [5:0] h, logic [7:0] l);
        return s ? {h, l} : {6'h00, l};
    endfunction

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd; pstrb <= 4'hf;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(string name, logic [11:0] a, logic [31:0] exp, logic [31:0] mask);
        apb(1'b0, a, 32'h0);
        chk(name, exp, r & mask);
    endtask
    task automatic end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end

    initial begin
        clk = 0; reset = 1; warm_reset = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
        seed = 32'h13aae5ef;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdc("ctl_reset", NVS_ACCESS_CONTROL_ADDR, 32'h0, 32'hff);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'hfc);
        rdc("ctl_unused", NVS_ACCESS_CONTROL_ADDR, 32'h8c, 32'hff);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'h00);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'h02);
        repeat (5) @(posedge clk);
        chk("erase_no_enable", 32'h0, mer);
        rdc("ctl_no_enable", NVS_ACCESS_CONTROL_ADDR, 32'h0, 32'hff);
        $display("test register_access end");
        // Writes to both arrays, corner values first
        for (i = 0; i < 4; i++) begin
            sel = i[0];
            d = (i < 2) ? 14'h3fff : xs() >> 4;
            lo = (i < 2) ? 8'hff : xs() >> 8;
            apb(1'b1, NVS_ADDRESS_LOW_ADDR, lo);
            apb(1'b1, NVS_ADDRESS_HIGH_ADDR, d[13:8]);
            apb(1'b1, NVS_DATA_LOW_ADDR, d[7:0]);
            apb(1'b1, NVS_DATA_HIGH_ADDR, d[13:8]);
            apb(1'b1, NVS_FLAGS_TWO_ADDR, 32'h0);
            apb(1'b1, NVS_ACCESS_CONTROL_ADDR, {sel, 7'h0c});
            apb(1'b1, NVS_ACCESS_CONTROL_ADDR, {sel, 7'h0e});
            repeat (10) @(posedge clk);
            chk("halt", sel, cpu_halt);
            n = 0;
            r = 32'h0;
            while (r[NVS_WRITE_COMPLETE_BIT] !== 1'b1 && n++ < 200) apb(1'b0, NVS_FLAGS_TWO_ADDR, 32'h0);
            chk("complete", 32'h1, r[NVS_WRITE_COMPLETE_BIT]);
            chk("halt_end", 32'h0, cpu_halt);
            rdc("ctl_done", NVS_ACCESS_CONTROL_ADDR, {sel, 7'h04}, 32'hff);
            chk("array", exp_word(sel, d[13:8], d[7:0]),
                sel ? mem.flash[{d[13:8], lo}] : mem.eeprom[lo]);
            apb(1'b1, NVS_DATA_LOW_ADDR, ~d[7:0]);
            apb(1'b1, NVS_DATA_HIGH_ADDR, ~d[13:8]);
            apb(1'b1, NVS_ACCESS_CONTROL_ADDR, {sel, 7'h01});
            repeat (3) @(posedge clk);
            rdc("read_low", NVS_DATA_LOW_ADDR, d[7:0], 32'hff);
            rdc("read_high", NVS_DATA_HIGH_ADDR, {26'h0, sel ? d[13:8] : ~d[13:8]}, 32'h3f);
            rdc("read_clear", NVS_ACCESS_CONTROL_ADDR, 32'h0, 32'h01);
            $display("test write_%0d end", i);
        end
        // Warm reset in mid-erase
        apb(1'b1, NVS_FLAGS_TWO_ADDR, 32'h0);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'h84);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'h86);
        repeat (20) @(posedge clk);
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        rdc("ctl_abort", NVS_ACCESS_CONTROL_ADDR, 32'h88, 32'h8e);
        rdc("addr_kept", NVS_ADDRESS_LOW_ADDR, lo, 32'hff);
        rdc("data_kept", NVS_DATA_LOW_ADDR, d[7:0], 32'hff);
        rdc("no_complete", NVS_FLAGS_TWO_ADDR, 32'h0, 32'h10);
        apb(1'b1, NVS_ACCESS_CONTROL_ADDR, 32'h00);
        rdc("err_clear", NVS_ACCESS_CONTROL_ADDR, 32'h0, 32'h08);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped", 32'h1, e);
        $display("test warm_reset end");
        end_of_test();
    end
endmodule
